//--- hdl/csac_pkg.sv
// package of constants and carrier types for the core store address control
// Function
// RULE1: a 15-bit address-hold register alone selects the accessed location
// RULE2: address-hold register stays unchanged until read and write phases finish
// RULE3: address bits 12 to 14 choose one of eight banks
// RULE4: a missing bank is replaced by an installed bank, same lower address
// RULE5: bits 0-5 pick one of 64 y lines, bits 6-11 one of 64 x lines
// RULE6: y source from bits 1,2,3; y diverter from bits 0,4,5
// RULE7: x source from bits 7,8,9; x diverter from bits 6,10,11
// RULE8: bits 4 and 5 pick one of four vertical inhibit stripes
// RULE9: bits 10 and 11 pick one of four horizontal inhibit stripes
// RULE10: read phase captures selected bank sense outputs into the data-word register
// RULE11: read access passes captured word to requester, then restores it
// RULE12: write access replaces data-word register with requester word and stores it
// RULE13: requesters give request plus write flag; device arbitrates and sequences timing
// RULE14: device releases the served requester; requester waits for that release
// RULE15: address-hold register loads about 75 ns after cycle start
// RULE16: load from channel address when channel granted, else processor address
// RULE17: wrap-around follows fixed mapping per installed bank count
// RULE18: in write phase each zero data bit drives inhibit for its plane
// RULE19: read strobe occurs about 475 ns into the cycle
// RULE20: write word strobed into data-word register about 600 ns into cycle
// RULE21: simultaneous requests grant the channel; processor waits until completion
`default_nettype none
package csac_pkg;
   localparam int unsigned ADDR_W = 15;
   localparam int unsigned DATA_W = 18;
   localparam int unsigned BANKS = 8;
   localparam int unsigned BANK_LSB = 12;
   localparam int unsigned CLK_MHZ = 10;
   // timing points within one storage cycle, in ns
   localparam int unsigned T_LOAD_NS = 75;
   localparam int unsigned T_STROBE_NS = 475;
   localparam int unsigned T_WSTROBE_NS = 600;
   localparam int unsigned T_INH_NS = 675;
   localparam int unsigned T_CYCLE_NS = 1100;
   // least times round up to whole cycles
   localparam int unsigned T_LOAD_CYC = (T_LOAD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_WSTROBE_CYC = (T_WSTROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_INH_CYC = (T_INH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_END_CYC = (T_CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TCNT_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;

   typedef enum logic [1:0] {CSAC_IDLE, CSAC_BUSY} csac_state_e;

   // one requester's side of a storage reference
   typedef struct packed {
      logic req;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } csac_req_s;

   // selections presented to the drive and inhibit decks
   typedef struct packed {
      logic [7:0] y_src;
      logic [7:0] y_div;
      logic [7:0] x_src;
      logic [7:0] x_div;
      logic [3:0] v_inh;
      logic [3:0] h_inh;
   } csac_line_s;

   function automatic logic [7:0] csac_one_of_8(input logic [2:0] code);
      csac_one_of_8 = 8'h01 << code;
   endfunction

   function automatic logic [3:0] csac_one_of_4(input logic [1:0] code);
      csac_one_of_4 = 4'h1 << code;
   endfunction
endpackage
`default_nettype wire

//--- hdl/csac_line_decode.sv
// drive-line and inhibit-stripe decode of the low twelve address bits
`default_nettype none
module csac_line_decode
(
   // address
   input wire logic [csac_pkg::ADDR_W-1:0] addr,
   // selections
   output csac_pkg::csac_line_s lines
);
   always_comb
   begin
      lines.y_src = csac_pkg::csac_one_of_8({addr[3], addr[2], addr[1]}); // [RULE5] [RULE6]
      lines.y_div = csac_pkg::csac_one_of_8({addr[5], addr[4], addr[0]}); // [RULE6]
      lines.x_src = csac_pkg::csac_one_of_8({addr[9], addr[8], addr[7]}); // [RULE5] [RULE7]
      lines.x_div = csac_pkg::csac_one_of_8({addr[11], addr[10], addr[6]}); // [RULE7]
      lines.v_inh = csac_pkg::csac_one_of_4(addr[5:4]); // [RULE8]
      lines.h_inh = csac_pkg::csac_one_of_4(addr[11:10]); // [RULE9]
   end
endmodule
`default_nettype wire

//--- hdl/csac_bank_map.sv
// bank designator to installed bank, with wrap-around
`default_nettype none
module csac_bank_map
(
   // designator and installed bank count minus one
   input wire logic [2:0] desig,
   input wire logic [2:0] last_bank,
   // bank actually referenced
   output logic [2:0] bank
);
   logic [2:0] low;
   always_comb
   begin
      low = (last_bank == 3'h1) ? {2'b00, desig[0]} : {1'b0, desig[1:0]};
      if (desig <= last_bank)
         bank = desig;
      else if (last_bank < 3'h4)
         bank = (low > last_bank) ? last_bank : low; // [RULE4] [RULE17]
      else if (last_bank == 3'h5)
         bank = {2'b10, desig[0]}; // [RULE17]
      else
         bank = last_bank; // [RULE17]
   end
endmodule
`default_nettype wire

//--- hdl/csac_core_ctrl.sv
// storage reference control: arbitration, address hold, decode, data-word register and timing
`default_nettype none
module csac_core_ctrl
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // requesters
   input wire csac_pkg::csac_req_s ext_req,
   input wire csac_pkg::csac_req_s cpu_req,
   // installed bank count minus one, a strap
   input wire logic [2:0] last_bank_pin,
   // sense amplifier outputs, one word per bank
   input wire logic [csac_pkg::BANKS-1:0][csac_pkg::DATA_W-1:0] sense_pin,
   // release and read data to requesters
   output logic ext_release,
   output logic cpu_release,
   output logic [csac_pkg::DATA_W-1:0] read_data,
   output logic busy,
   // stack drive
   output logic [csac_pkg::ADDR_W-1:0] addr_hold,
   output csac_pkg::csac_line_s line_sel,
   output logic [csac_pkg::BANKS-1:0] bank_sel,
   output logic read_drive,
   output logic write_drive,
   output logic [csac_pkg::DATA_W-1:0] inhibit_planes
);
   localparam int LC_END = csac_pkg::T_END_CYC;
   localparam logic [csac_pkg::TCNT_W-1:0] C_LOAD = csac_pkg::TCNT_W'(csac_pkg::T_LOAD_CYC);
   localparam logic [csac_pkg::TCNT_W-1:0] C_STROBE = csac_pkg::TCNT_W'(csac_pkg::T_STROBE_CYC);
   localparam logic [csac_pkg::TCNT_W-1:0] C_WSTROBE = csac_pkg::TCNT_W'(csac_pkg::T_WSTROBE_CYC);
   localparam logic [csac_pkg::TCNT_W-1:0] C_INH = csac_pkg::TCNT_W'(csac_pkg::T_INH_CYC);
   localparam logic [csac_pkg::TCNT_W-1:0] C_LAST = csac_pkg::TCNT_W'(csac_pkg::T_END_CYC - 1);

   csac_pkg::csac_state_e state_reg;
   logic [csac_pkg::TCNT_W-1:0] t_reg;
   logic ext_grant_reg;
   logic cpu_grant_reg;
   logic busy_reg;
   logic write_reg;
   logic [csac_pkg::ADDR_W-1:0] addr_reg;
   logic [csac_pkg::DATA_W-1:0] z_reg;
   logic [csac_pkg::DATA_W-1:0] rd_data_reg;
   logic ext_release_reg;
   logic cpu_release_reg;
   logic read_drive_reg;
   logic write_drive_reg;
   logic inh_en_reg;
   logic [csac_pkg::DATA_W-1:0] inh_planes_reg;
   csac_pkg::csac_line_s line_reg;
   logic [csac_pkg::BANKS-1:0] bank_sel_reg;
   logic [csac_pkg::BANKS-1:0][csac_pkg::DATA_W-1:0] sense_meta_reg;
   logic [csac_pkg::BANKS-1:0][csac_pkg::DATA_W-1:0] sense_sync_reg;
   logic [2:0] strap_meta_reg;
   logic [2:0] strap_sync_reg;
   logic [2:0] last_bank_reg;

   csac_pkg::csac_line_s line_next;
   logic [2:0] bank_next;
   logic grant_ok;
   logic at_load;
   logic at_strobe;
   logic at_wstrobe;
   logic at_last;

   // sense outputs and bank strap come from outside the clock domain
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sense_meta_reg <= '0;
         sense_sync_reg <= '0;
      end
      else
      begin
         sense_meta_reg <= sense_pin;
         sense_sync_reg <= sense_meta_reg;
      end
   end

   // strap is caught after reset release through its own synchroniser
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_meta_reg <= 3'h0;
         strap_sync_reg <= 3'h0;
         last_bank_reg <= 3'h0;
      end
      else
      begin
         strap_meta_reg <= last_bank_pin;
         strap_sync_reg <= strap_meta_reg;
         last_bank_reg <= strap_sync_reg;
      end
   end

   assign at_load = (state_reg == csac_pkg::CSAC_BUSY) && (t_reg == C_LOAD);
   assign at_strobe = (state_reg == csac_pkg::CSAC_BUSY) && (t_reg == C_STROBE);
   assign at_wstrobe = (state_reg == csac_pkg::CSAC_BUSY) && (t_reg == C_WSTROBE);
   assign at_last = (state_reg == csac_pkg::CSAC_BUSY) && (t_reg == C_LAST);
   // a request still high in its release cycle is the old one, so grant waits a cycle
   assign grant_ok = (state_reg == csac_pkg::CSAC_IDLE) && !ext_release_reg && !cpu_release_reg;

   // arbitration and cycle timing
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= csac_pkg::CSAC_IDLE;
         t_reg <= '0;
         ext_grant_reg <= 1'b0;
         cpu_grant_reg <= 1'b0;
         write_reg <= 1'b0;
         busy_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            csac_pkg::CSAC_IDLE:
            begin
               t_reg <= '0;
               if (grant_ok && (ext_req.req || cpu_req.req)) // [RULE13]
               begin
                  state_reg <= csac_pkg::CSAC_BUSY;
                  busy_reg <= 1'b1;
                  ext_grant_reg <= ext_req.req; // [RULE21]
                  cpu_grant_reg <= !ext_req.req;
                  write_reg <= ext_req.req ? ext_req.write : cpu_req.write; // [RULE13]
               end
            end
            csac_pkg::CSAC_BUSY:
            begin
               t_reg <= t_reg + 1'b1;
               if (at_last)
               begin
                  state_reg <= csac_pkg::CSAC_IDLE;
                  busy_reg <= 1'b0;
                  ext_grant_reg <= 1'b0;
                  cpu_grant_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   // release pulse to whichever requester was served
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_release_reg <= 1'b0;
         cpu_release_reg <= 1'b0;
      end
      else
      begin
         ext_release_reg <= at_last && ext_grant_reg; // [RULE14]
         cpu_release_reg <= at_last && cpu_grant_reg; // [RULE14]
      end
   end

   // address hold: loaded once per reference, held to the end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         addr_reg <= csac_pkg::ADDR_RST;
      else if (at_load) // [RULE2] [RULE15]
         addr_reg <= ext_grant_reg ? ext_req.addr : cpu_req.addr; // [RULE1] [RULE16]
   end

   csac_line_decode u_line_decode
   (
      .addr(addr_reg),
      .lines(line_next)
   );

   csac_bank_map u_bank_map
   (
      .desig(addr_reg[csac_pkg::BANK_LSB +: 3]),
      .last_bank(last_bank_reg),
      .bank(bank_next)
   );

   // deck selections follow the held address
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_reg <= '0;
         bank_sel_reg <= '0;
      end
      else
      begin
         line_reg <= line_next; // [RULE5]
         bank_sel_reg <= csac_pkg::csac_one_of_8(bank_next); // [RULE3] [RULE4]
      end
   end

   // data-word register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         z_reg <= csac_pkg::DATA_RST;
      else if (at_strobe)
         z_reg <= sense_sync_reg[bank_next]; // [RULE10] [RULE19]
      else if (at_wstrobe && write_reg)
         z_reg <= ext_grant_reg ? ext_req.wdata : cpu_req.wdata; // [RULE12] [RULE20]
   end

   // word read goes to the requester; z keeps it for the restore
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data_reg <= csac_pkg::DATA_RST;
      else if (at_wstrobe && !write_reg)
         rd_data_reg <= z_reg; // [RULE11]
   end

   // drive and inhibit phases
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         read_drive_reg <= 1'b0;
         write_drive_reg <= 1'b0;
         inh_en_reg <= 1'b0;
         inh_planes_reg <= '0;
      end
      else
      begin
         read_drive_reg <= (state_reg == csac_pkg::CSAC_BUSY) && (t_reg >= C_LOAD) && (t_reg < C_STROBE);
         write_drive_reg <= (state_reg == csac_pkg::CSAC_BUSY) && (t_reg >= C_INH) && (t_reg < C_LAST);
         inh_en_reg <= (state_reg == csac_pkg::CSAC_BUSY) && (t_reg >= C_INH) && (t_reg < C_LAST);
         // planes holding a zero are inhibited so the write cannot set them
         inh_planes_reg <= ((state_reg == csac_pkg::CSAC_BUSY) && (t_reg >= C_INH) && (t_reg < C_LAST))
            ? ~z_reg : '0; // [RULE18]
      end
   end

   assign ext_release = ext_release_reg;
   assign cpu_release = cpu_release_reg;
   assign read_data = rd_data_reg;
   // own flop so the pin is not a decode of the state code
   assign busy = busy_reg;
   assign addr_hold = addr_reg;
   assign line_sel = line_reg;
   assign bank_sel = bank_sel_reg;
   assign read_drive = read_drive_reg;
   assign write_drive = write_drive_reg;
   assign inhibit_planes = inh_planes_reg;

   // checks

   sequence s_start;
      grant_ok && (ext_req.req || cpu_req.req);
   endsequence

   sequence s_hold_phase;
      busy && (t_reg > C_LOAD) && !at_last;
   endsequence

   property p_addr_stable;
      @(posedge core_clk) disable iff (!rst_n)
      s_hold_phase |=> $stable(addr_reg);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address hold changed mid reference"); // [RULE2]

   property p_ext_load;
      @(posedge core_clk) disable iff (!rst_n)
      at_load && ext_grant_reg |=> addr_reg == $past(ext_req.addr);
   endproperty
   a_ext_load: assert property (p_ext_load) else $error("channel address not loaded"); // [RULE16]

   property p_cpu_load;
      @(posedge core_clk) disable iff (!rst_n)
      s_start ##1 (cpu_grant_reg && t_reg == 0) ##1 1'b1 |=> addr_reg == $past(cpu_req.addr);
   endproperty
   a_cpu_load: assert property (p_cpu_load) else $error("processor address not loaded at 75 ns"); // [RULE15]

   property p_priority;
      @(posedge core_clk) disable iff (!rst_n)
      s_start ##0 (ext_req.req && cpu_req.req) |=> ext_grant_reg && !cpu_grant_reg;
   endproperty
   a_priority: assert property (p_priority) else $error("channel did not win arbitration"); // [RULE21]

   property p_release;
      @(posedge core_clk) disable iff (!rst_n)
      // release is registered off the last count, so it is seen one edge later
      s_start |-> ##LC_END 1'b1 ##1 (ext_release || cpu_release) ##1 !(ext_release || cpu_release);
   endproperty
   a_release: assert property (p_release) else $error("release not one pulse at cycle end"); // [RULE14]

   property p_read_strobe;
      @(posedge core_clk) disable iff (!rst_n)
      at_strobe |=> z_reg == $past(sense_sync_reg[bank_next]);
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("sense word not captured at 475 ns"); // [RULE19]

   property p_write_strobe;
      @(posedge core_clk) disable iff (!rst_n)
      at_wstrobe && write_reg && cpu_grant_reg |=> z_reg == $past(cpu_req.wdata);
   endproperty
   a_write_strobe: assert property (p_write_strobe) else $error("write word not taken at 600 ns"); // [RULE20]

   property p_read_back;
      @(posedge core_clk) disable iff (!rst_n)
      at_wstrobe && !write_reg |=> (read_data == $past(z_reg)) && $stable(z_reg);
   endproperty
   a_read_back: assert property (p_read_back) else $error("read word not passed or not kept"); // [RULE11]

   property p_inhibit;
      @(posedge core_clk) disable iff (!rst_n)
      write_drive |-> inhibit_planes == ~z_reg;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit planes differ from zero bits"); // [RULE18]

   property p_decode;
      @(posedge core_clk) disable iff (!rst_n)
      busy && $stable(addr_reg) |=> line_sel.v_inh == csac_pkg::csac_one_of_4($past(addr_reg[5:4]))
         && line_sel.x_src == csac_pkg::csac_one_of_8($past(addr_reg[9:7]));
   endproperty
   a_decode: assert property (p_decode) else $error("line decode mismatch"); // [RULE8]

   property p_bank_onehot;
      @(posedge core_clk) disable iff (!rst_n)
      busy |=> $onehot(bank_sel) && (bank_sel <= (8'h01 << last_bank_reg));
   endproperty
   a_bank_onehot: assert property (p_bank_onehot) else $error("bank select not an installed bank"); // [RULE4]
endmodule
`default_nettype wire

//--- bench/csac_far_side.sv
// far side models: one storage requester, and the core stack with its sense amplifiers
`default_nettype none
module csac_requester
(
   // clock
   input wire logic core_clk,
   // answer from the store
   input wire logic rel,
   input wire logic [17:0] read_data,
   // request to the store
   output var csac_pkg::csac_req_s req_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int done_cnt = 0;
   int lat = 0;
   logic [17:0] got = 18'h0_0000;
   initial req_out = '0;
   task automatic start(input logic wr, input logic [14:0] a, input logic [17:0] d);
      lat = 0;
      req_out = {1'b1, wr, a, d};
   endtask
   always @(posedge core_clk)
      if (req_out.req)
         lat <= lat + 1;
   // everything is held until the release; after it req drops and addr and wdata no longer show the old values
   always @(negedge core_clk)
      if (req_out.req && rel)
      begin
         got = read_data;
         req_out.req = 1'b0;
         req_out.addr = ~req_out.addr;
         req_out.wdata = ~req_out.wdata;
         done_cnt++;
      end
endmodule

module csac_stack
(
   // clock
   input wire logic core_clk,
   // drive from the store
   input wire logic [14:0] addr_hold,
   input wire logic [7:0] bank_sel,
   input wire logic read_drive,
   input wire logic write_drive,
   input wire logic [17:0] inhibit_planes,
   // sense amplifier words
   output var logic [7:0][17:0] sense_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [17:0] mem [8][4096];
   logic [17:0] idle_pat = 18'h2_AAAA;
   initial
      for (int b = 0; b < 8; b++)
         for (int a = 0; a < 4096; a++)
            mem[b][a] = {3'(b), 12'(a), 3'(b)};
   // a plane stores a one unless its inhibit is driven
   always @(posedge core_clk)
   begin
      idle_pat <= ~idle_pat;
      for (int b = 0; b < 8; b++)
         if (write_drive && bank_sel[b])
            mem[b][addr_hold[11:0]] <= ~inhibit_planes;
   end
   // idle amplifiers toggle so a stale word can never pass as a good read
   always_comb
      for (int b = 0; b < 8; b++)
         sense_pin[b] = (read_drive && bank_sel[b]) ? mem[b][addr_hold[11:0]] : idle_pat ^ 18'(b);
endmodule
`default_nettype wire

//--- bench/core_store_address_control_test.sv
// self-checking bench for the core store address control
`default_nettype none
module core_store_address_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIMIT = 3000;
   localparam logic [31:0] MAP [8] = '{32'h0000_0000, 32'h0101_0101, 32'h0122_0122, 32'h0123_0123,
      32'h0123_4444, 32'h0123_4545, 32'h0123_4566, 32'h0123_4567};
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] last_bank_pin = 3'h7;
   csac_pkg::csac_req_s ext_req;
   csac_pkg::csac_req_s cpu_req;
   logic [7:0][17:0] sense_pin;
   logic ext_release;
   logic cpu_release;
   logic busy;
   logic read_drive;
   logic write_drive;
   logic [17:0] read_data;
   logic [17:0] inhibit_planes;
   logic [14:0] addr_hold;
   logic [7:0] bank_sel;
   csac_pkg::csac_line_s line_sel;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;

   csac_core_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .ext_req(ext_req), .cpu_req(cpu_req),
      .last_bank_pin(last_bank_pin), .sense_pin(sense_pin), .ext_release(ext_release),
      .cpu_release(cpu_release), .read_data(read_data), .busy(busy), .addr_hold(addr_hold),
      .line_sel(line_sel), .bank_sel(bank_sel), .read_drive(read_drive), .write_drive(write_drive),
      .inhibit_planes(inhibit_planes));
   csac_requester i_ext (.core_clk(core_clk), .rel(ext_release), .read_data(read_data), .req_out(ext_req));
   csac_requester i_cpu (.core_clk(core_clk), .rel(cpu_release), .read_data(read_data), .req_out(cpu_req));
   csac_stack i_stack (.core_clk(core_clk), .addr_hold(addr_hold), .bank_sel(bank_sel),
      .read_drive(read_drive), .write_drive(write_drive), .inhibit_planes(inhibit_planes),
      .sense_pin(sense_pin));

   always #50 core_clk = ~core_clk;

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         err_total++;
         $display("unexpected cycle count: expected below %0d seen %0d", LIMIT, cyc);
         end_sim();
      end
   end

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [2:0] bank_of(input logic [2:0] desig);
      logic [31:0] row;
      row = MAP[last_bank_pin];
      bank_of = row[28 - 4 * int'(desig) +: 3];
   endfunction

   function automatic logic [17:0] word_of(input logic [14:0] a);
      logic [2:0] b;
      b = bank_of(a[14:12]);
      word_of = {b, a[11:0], b};
   endfunction

   function automatic csac_pkg::csac_line_s dec(input logic [14:0] a);
      dec.y_src = 8'h01 << a[3:1];
      dec.y_div = 8'h01 << {a[5:4], a[0]};
      dec.x_src = 8'h01 << a[9:7];
      dec.x_div = 8'h01 << {a[11:10], a[6]};
      dec.v_inh = 4'h1 << a[5:4];
      dec.h_inh = 4'h1 << a[11:10];
   endfunction

   // one whole reference from either requester, judged cycle by cycle
   task automatic run(input logic ext, input logic wr, input logic [14:0] a, input logic [17:0] d,
      input logic [17:0] exp);
      int n;
      logic [2:0] b;
      logic [17:0] inv;
      // a request raised in the release cycle is not taken, so leave that cycle first
      @(negedge core_clk);
      b = bank_of(a[14:12]);
      inv = ~exp;
      n = ext ? i_ext.done_cnt : i_cpu.done_cnt;
      if (ext)
         i_ext.start(wr, a, d);
      else
         i_cpu.start(wr, a, d);
      for (int i = 0; i < 30 && (ext ? i_ext.done_cnt : i_cpu.done_cnt) == n; i++)
      begin
         @(negedge core_clk);
         if (read_drive || write_drive)
            check("addr_hold", 40'(addr_hold), 40'(a));
         if (write_drive)
            check("inhibit_planes", 40'(inhibit_planes), 40'(inv));
      end
      check("latency", 40'(ext ? i_ext.lat : i_cpu.lat), 40'd12);
      check("busy after release", 40'(busy), 40'd0);
      if (!wr)
         check("read word", 40'(ext ? i_ext.got : i_cpu.got), 40'(exp));
      check("bank_sel", 40'(bank_sel), 40'(8'h01 << b));
      check("line_sel", 40'(line_sel), 40'(dec(a)));
   endtask

   task automatic t_reset();
      repeat (20) @(negedge core_clk);
      check("outputs in reset", 40'({busy, read_drive, write_drive, ext_release, cpu_release, bank_sel,
         inhibit_planes}), 40'd0);
      check("address and data in reset", 40'({addr_hold, read_data}), 40'd0);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      check("line_sel", 40'(line_sel), 40'(dec(15'h0000)));
      $display("test reset done");
   endtask

   // every source and diverter code of both decks, alternating requesters
   task automatic t_lines();
      logic [2:0] p;
      logic [2:0] q;
      logic [2:0] r;
      logic [2:0] s;
      logic [14:0] a;
      for (int i = 0; i < 8; i++)
      begin
         p = 3'(i);
         q = ~p;
         r = p ^ 3'h5;
         s = ~r;
         a = {p, s[2:1], r, s[0], q[2:1], p, q[0]};
         run(p[0], 1'b0, a, 18'h0_0000, word_of(a));
      end
      $display("test lines done");
   endtask

   task automatic t_banks();
      logic [14:0] a;
      for (int lb = 0; lb < 8; lb++)
      begin
         last_bank_pin = 3'(lb);
         repeat (4) @(negedge core_clk);
         for (int d = 0; d < 8; d++)
         begin
            a = {3'(d), 12'h5A3 + 12'(d)};
            run(1'b0, 1'b0, a, 18'h0_0000, word_of(a));
         end
      end
      $display("test banks done");
   endtask

   task automatic t_write();
      run(1'b1, 1'b1, 15'h31C7, 18'h2_5A1C, 18'h2_5A1C);
      run(1'b0, 1'b0, 15'h31C7, 18'h0_0000, 18'h2_5A1C);
      run(1'b0, 1'b1, 15'h31C7, 18'h0_0000, 18'h0_0000);
      run(1'b1, 1'b0, 15'h31C7, 18'h3_FFFF, 18'h0_0000);
      $display("test write done");
   endtask

   // simultaneous requests to one address: the channel write must land before the processor read
   task automatic t_tie();
      int n;
      n = i_cpu.done_cnt;
      @(negedge core_clk);
      i_ext.start(1'b1, 15'h62B4, 18'h1_3C5A);
      i_cpu.start(1'b0, 15'h62B4, 18'h0_0000);
      for (int i = 0; i < 40 && i_cpu.done_cnt == n; i++)
      begin
         @(negedge core_clk);
         if (ext_release)
            check("processor pending", 40'(i_cpu.done_cnt - n), 40'd0);
      end
      check("channel latency", 40'(i_ext.lat), 40'd12);
      check("processor word", 40'(i_cpu.got), 40'(18'h1_3C5A));
      check("processor wait", 40'(i_cpu.lat > 12 && i_cpu.lat < 30), 40'd1);
      $display("test tie done");
   endtask

   initial
   begin
      t_reset();
      t_lines();
      t_banks();
      t_write();
      t_tie();
      end_sim();
   end
endmodule
`default_nettype wire
